// [rtl/mrdec_top.sv]
`default_nettype none
// Summary of operation
// R1: Dynamic termination select from register two A10:A9.
// R2: Write leveling forces nominal termination only.
// R3: Bit 7 clear keeps single self-refresh rate.
// R4: Bit 7 set doubles self-refresh rate.
// R5: Controller halves refresh interval when hot.
// R6: Controller avoids hot self refresh unless bit set.
// R7: Controller programs A6/A7 before hot self refresh.
// R8: Register three loads on set command, BA=3.
// R9: Controller zeroes reserved bits of register three.
// R10: Readout disabled means pattern bits ignored.
// R11: Readout enabled returns fixed pattern on reads.
// R12: Register two loads on set command, BA=2.
// R13: Controller zeroes A10:A9 while DLL is off.
// R14: Hold fields, decode them continuously.
module mrdec_top (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Command clock and command pins from the controller.
  input  wire logic              cmd_clk_i,
  input  wire mrdec_pkg::mrdec_cmd_t cmd_i,
  // Device state inputs.
  input  wire logic              write_leveling_i,
  input  wire logic              write_active_i,
  input  wire logic              read_active_i,
  // Decoded outputs.
  output logic [13:0]            mode_register_two_o,
  output logic [13:0]            mode_register_three_o,
  output mrdec_pkg::mrdec_ctrl_t ctrl_o,
  output logic [7:0]             read_data_o
);
  import mrdec_pkg::*;

  // Two-stage synchronisers for all pins but the reset; stage one feeds stage two only.
  // The command clock gets a third flop so that its rising edge can be found.
  logic        clk_s1_q, clk_s2_q, clk_s3_q;
  mrdec_cmd_t  cmd_s1_q, cmd_s2_q;
  logic [2:0]  st_s1_q, st_s2_q;
  always_ff @(posedge clk_i) begin
    clk_s1_q <= cmd_clk_i;
    clk_s2_q <= clk_s1_q;
    clk_s3_q <= clk_s2_q;
    cmd_s1_q <= cmd_i;
    cmd_s2_q <= cmd_s1_q;
    st_s1_q  <= {write_leveling_i, write_active_i, read_active_i};
    st_s2_q  <= st_s1_q;
  end

  // Synchronised device state, named by what each bit means.
  logic lvl_s;
  logic wr_s;
  logic rd_s;
  assign lvl_s = st_s2_q[2];
  assign wr_s  = st_s2_q[1];
  assign rd_s  = st_s2_q[0];

  // Command pins are taken on the rising edge of the command clock.
  // The pins are synchronised bit by bit, so they must hold for a few system
  // clocks around that edge; a skewed word would be stored otherwise.
  logic cmd_edge;
  logic is_set_cmd;
  logic set_edge;
  logic take_two;
  logic take_three;
  assign cmd_edge   = clk_s2_q & ~clk_s3_q;
  assign is_set_cmd = ~cmd_s2_q.cs_n & ~cmd_s2_q.ras_n & ~cmd_s2_q.cas_n & ~cmd_s2_q.we_n;
  assign set_edge   = cmd_edge & is_set_cmd;
  assign take_two   = set_edge && (cmd_s2_q.ba == MRDEC_BA_MODE_REG_TWO);   // see R12
  assign take_three = set_edge && (cmd_s2_q.ba == MRDEC_BA_MODE_REG_THREE); // see R8

  // Register storage; a field holds until the next matching set command.
  logic [13:0] reg_two_q, reg_two_d, reg_three_q, reg_three_d;
  always_comb begin
    reg_two_d   = reg_two_q;
    reg_three_d = reg_three_q;
    if (take_two) begin
      reg_two_d = cmd_s2_q.addr; // see R14
    end
    if (take_three) begin
      // Reserved bits are stored as sent; keeping them zero is the sender's duty.
      reg_three_d = cmd_s2_q.addr; // see R9
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_two_q   <= MRDEC_MODE_TWO_RESET;
      reg_three_q <= MRDEC_MODE_THREE_RESET;
    end else begin
      reg_two_q   <= reg_two_d;
      reg_three_q <= reg_three_d;
    end
  end

  // Continuous decode of stored fields into controls, registered at the outputs.
  mrdec_ctrl_t ctrl_d;
  logic [7:0]  rd_d;
  always_comb begin
    ctrl_d.rtt_wr_sel          = reg_two_q[MRDEC_RTT_WR_LSB +: 2]; // see R1
    // Leveling pins termination at nominal; a write switches without a new command.
    ctrl_d.dyn_odt_active      = (ctrl_d.rtt_wr_sel != 2'h0) && wr_s
                                 && !lvl_s; // see R1, see R2
    ctrl_d.self_refresh_double = reg_two_q[MRDEC_SR_TEMP_BIT]; // see R3, see R4
    ctrl_d.readout_enable      = reg_three_q[MRDEC_READOUT_EN_BIT]; // see R14
    // Pattern select forced to zero while readout is off.
    ctrl_d.readout_pattern_sel = reg_three_q[MRDEC_READOUT_EN_BIT] ?
                                 reg_three_q[MRDEC_PATTERN_LSB +: 2] : 2'h0; // see R10
    rd_d = (ctrl_d.readout_enable && rd_s) ? MRDEC_READOUT_PATTERN : 8'h00; // see R11
  end
  // Outputs come from flops, which costs one clock of lag after each load.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_o                <= '0;
      read_data_o           <= 8'h00;
      mode_register_two_o   <= MRDEC_MODE_TWO_RESET;
      mode_register_three_o <= MRDEC_MODE_THREE_RESET;
    end else begin
      ctrl_o                <= ctrl_d;
      read_data_o           <= rd_d;
      mode_register_two_o   <= reg_two_q;
      mode_register_three_o <= reg_three_q;
    end
  end

  // The refresh rate follows the stored temperature bit one clock later.
  property p_sr_rate;
    @(posedge clk_i) disable iff (reset_i)
    ##1 ctrl_o.self_refresh_double == $past(reg_two_q[MRDEC_SR_TEMP_BIT]);
  endproperty
  a_sr_rate: assert property (p_sr_rate) else $error("Self-refresh rate mismatch."); // see R4

  // A clear temperature bit keeps the single rate.
  property p_sr_single;
    @(posedge clk_i) disable iff (reset_i)
    !reg_two_q[MRDEC_SR_TEMP_BIT] |=> !ctrl_o.self_refresh_double;
  endproperty
  a_sr_single: assert property (p_sr_single) else $error("Rate not single."); // see R3

  // A set temperature bit doubles the rate.
  property p_sr_double;
    @(posedge clk_i) disable iff (reset_i)
    reg_two_q[MRDEC_SR_TEMP_BIT] |=> ctrl_o.self_refresh_double;
  endproperty
  a_sr_double: assert property (p_sr_double) else $error("Rate not doubled."); // see R4

  // Leveling never lets the write termination through.
  property p_level_nominal;
    @(posedge clk_i) disable iff (reset_i)
    lvl_s |=> !ctrl_o.dyn_odt_active;
  endproperty
  a_level_nominal: assert property (p_level_nominal) else $error("Dynamic odt in leveling."); // see R2

  // A write with a non-zero select switches termination without a command.
  property p_dyn_write;
    @(posedge clk_i) disable iff (reset_i)
    (reg_two_q[MRDEC_RTT_WR_LSB +: 2] != 2'h0 && wr_s && !lvl_s) |=> ctrl_o.dyn_odt_active;
  endproperty
  a_dyn_write: assert property (p_dyn_write) else $error("Dynamic odt missed."); // see R1

  // A taken command for register two shows at the port two clocks later.
  property p_two_load;
    @(posedge clk_i) disable iff (reset_i)
    take_two |=> ##1 mode_register_two_o == $past(cmd_s2_q.addr, 2);
  endproperty
  a_two_load: assert property (p_two_load) else $error("Register two load missed."); // see R12

  // A taken command for register three shows at the port two clocks later.
  property p_three_load;
    @(posedge clk_i) disable iff (reset_i)
    take_three |=> ##1 mode_register_three_o == $past(cmd_s2_q.addr, 2);
  endproperty
  a_three_load: assert property (p_three_load) else $error("Register three load missed."); // see R8

  // Without a set command neither register moves.
  property p_hold;
    @(posedge clk_i) disable iff (reset_i)
    !set_edge |=> $stable(reg_two_q) && $stable(reg_three_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Register changed without command."); // see R14

  // A set command for another bank leaves register two alone.
  property p_two_other_bank;
    @(posedge clk_i) disable iff (reset_i)
    (set_edge && cmd_s2_q.ba != MRDEC_BA_MODE_REG_TWO) |=> $stable(reg_two_q);
  endproperty
  a_two_other_bank: assert property (p_two_other_bank) else $error("Two loaded wrongly."); // see R12

  // A set command for another bank leaves register three alone.
  property p_three_other_bank;
    @(posedge clk_i) disable iff (reset_i)
    (set_edge && cmd_s2_q.ba != MRDEC_BA_MODE_REG_THREE) |=> $stable(reg_three_q);
  endproperty
  a_three_other_bank: assert property (p_three_other_bank) else $error("Three loaded wrongly."); // see R8

  // Readout off hides the pattern select bits.
  property p_ignore_pattern;
    @(posedge clk_i) disable iff (reset_i)
    !reg_three_q[MRDEC_READOUT_EN_BIT] |=> ctrl_o.readout_pattern_sel == 2'h0;
  endproperty
  a_ignore_pattern: assert property (p_ignore_pattern) else $error("Pattern not ignored."); // see R10

  // Readout on passes the pattern select bits.
  property p_pass_pattern;
    @(posedge clk_i) disable iff (reset_i)
    reg_three_q[MRDEC_READOUT_EN_BIT] |=>
      ctrl_o.readout_pattern_sel == $past(reg_three_q[MRDEC_PATTERN_LSB +: 2]);
  endproperty
  a_pass_pattern: assert property (p_pass_pattern) else $error("Pattern not passed."); // see R14

  // A read with readout on returns the fixed pattern.
  property p_readout;
    @(posedge clk_i) disable iff (reset_i)
    (reg_three_q[MRDEC_READOUT_EN_BIT] && rd_s) |=> read_data_o == MRDEC_READOUT_PATTERN;
  endproperty
  a_readout: assert property (p_readout) else $error("Readout pattern wrong."); // see R11

  // Without readout or without a read the data port stays zero.
  property p_readout_idle;
    @(posedge clk_i) disable iff (reset_i)
    !(reg_three_q[MRDEC_READOUT_EN_BIT] && rd_s) |=> read_data_o == 8'h00;
  endproperty
  a_readout_idle: assert property (p_readout_idle) else $error("Readout data not idle."); // see R11

  // The termination select mirrors the stored field.
  property p_rtt_sel;
    @(posedge clk_i) disable iff (reset_i)
    1'b1 |=> ctrl_o.rtt_wr_sel == $past(reg_two_q[MRDEC_RTT_WR_LSB +: 2]);
  endproperty
  a_rtt_sel: assert property (p_rtt_sel) else $error("Termination select mismatch."); // see R1

  // The register ports mirror the stored words.
  property p_ports_mirror;
    @(posedge clk_i) disable iff (reset_i)
    1'b1 |=> mode_register_two_o == $past(reg_two_q)
             && mode_register_three_o == $past(reg_three_q);
  endproperty
  a_ports_mirror: assert property (p_ports_mirror) else $error("Register ports stale."); // see R14
endmodule // mrdec_top
`default_nettype wire

// [rtl/mrdec_pkg.sv]
`default_nettype none
package mrdec_pkg;
  // Command pin group as sampled on the command clock.
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] addr;
  } mrdec_cmd_t;

  // Decoded controls driven to the rest of the device.
  typedef struct packed {
    logic [1:0] rtt_wr_sel;
    logic       dyn_odt_active;
    logic       self_refresh_double;
    logic       readout_enable;
    logic [1:0] readout_pattern_sel;
  } mrdec_ctrl_t;

  localparam logic [2:0] MRDEC_BA_MODE_REG_TWO   = 3'h2;
  localparam logic [2:0] MRDEC_BA_MODE_REG_THREE = 3'h3;
  localparam int         MRDEC_RTT_WR_LSB        = 9;
  localparam int         MRDEC_SR_TEMP_BIT       = 7;
  localparam int         MRDEC_ASR_BIT           = 6;
  localparam int         MRDEC_READOUT_EN_BIT    = 2;
  localparam int         MRDEC_PATTERN_LSB       = 0;
  localparam logic [13:0] MRDEC_MODE_TWO_RESET   = 14'h0000;
  localparam logic [13:0] MRDEC_MODE_THREE_RESET = 14'h0000;
  // Fixed readout pattern used for read capture alignment.
  localparam logic [7:0] MRDEC_READOUT_PATTERN   = 8'h55;
endpackage
`default_nettype wire

// [dv/mrdec_ctl_model.sv]
`default_nettype none
module mrdec_ctl_model (
  // Clock and command pins.
  input  wire logic             clk_i,
  output logic                  cmd_clk_o,
  output mrdec_pkg::mrdec_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import mrdec_pkg::*;
  // The command clock stands still outside a frame.
  initial begin
    cmd_clk_o = 1'b0;
    cmd_o = '1;
  end
  // One frame; a low ok raises the write strobe so the command is not a set.
  task automatic send(input logic [2:0] ba, input logic [13:0] a, input logic ok);
    cmd_o = {3'h0, ~ok, ba, a};
    repeat (4) @(negedge clk_i);
    cmd_clk_o = 1'b1;
    repeat (4) @(negedge clk_i);
    cmd_clk_o = 1'b0;
    repeat (4) @(negedge clk_i);
    // Released pins show the inverse, so a stale command cannot pass.
    cmd_o = {1'b1, ~cmd_o[19:0]};
    // One more clock so a following frame never reassigns pins in this step.
    @(negedge clk_i);
  endtask
endmodule // mrdec_ctl_model
`default_nettype wire

// [dv/tb_mrdec_top.sv]
`default_nettype none
module tb_mrdec_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mrdec_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        lvl = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        cclk;
  mrdec_cmd_t  cmd;
  logic [13:0] reg_two;
  logic [13:0] reg_three;
  mrdec_ctrl_t ctrl;
  logic [7:0]  rdat;
  logic [13:0] a;
  int          err_total = 0;
  int          checked = 0;
  // Clock of 50 ns.
  always #25 clk_i = ~clk_i;
  mrdec_ctl_model u_ctl (.clk_i(clk_i), .cmd_clk_o(cclk), .cmd_o(cmd));
  mrdec_top DUT (.clk_i(clk_i), .reset_i(reset_i), .cmd_clk_i(cclk), .cmd_i(cmd),
    .write_leveling_i(lvl), .write_active_i(wr), .read_active_i(rd),
    .mode_register_two_o(reg_two), .mode_register_three_o(reg_three), .ctrl_o(ctrl),
    .read_data_o(rdat));
  // Case inequality so an unknown never matches.
  task automatic cmp(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Every select and both refresh-rate settings, then termination under writes.
  // Passes 0 and 4 send select 0, which turns dynamic termination off as a controller must with the
  // loop disabled; a set bit 7 is the controller's setting for hot self refresh.
  task automatic t_reg_two();
    for (int i = 0; i < 8; i++) begin
      a = {3'h0, i[1:0], 1'b0, i[2], ~i[2], 6'h0};
      u_ctl.send(3'h2, a, 1'b1);
      cmp(reg_two, a);
      cmp(ctrl.rtt_wr_sel, i[1:0]);
      cmp(ctrl.self_refresh_double, i[2]);
      wr = 1'b1;
      lvl = i[0];
      repeat (5) @(negedge clk_i);
      cmp(ctrl.dyn_odt_active, (i[1:0] != 0) & ~i[0]);
      wr = 1'b0;
    end
    $display("test reg_two done");
  endtask
  // Readout on and off with every pattern select, reading each time.
  task automatic t_reg_three();
    for (int i = 0; i < 8; i++) begin
      a = {11'h0, i[2:0]};
      u_ctl.send(3'h3, a, 1'b1);
      rd = 1'b1;
      repeat (5) @(negedge clk_i);
      cmp(reg_three, a);
      cmp(ctrl.readout_enable, i[2]);
      cmp(ctrl.readout_pattern_sel, i[2] ? i[1:0] : 2'h0);
      cmp(rdat, i[2] ? MRDEC_READOUT_PATTERN : 8'h00);
      rd = 1'b0;
    end
    $display("test reg_three done");
  endtask
  // Other banks and non-set commands leave both registers alone.
  task automatic t_hold();
    u_ctl.send(3'h1, 14'h3fff, 1'b1);
    u_ctl.send(3'h3, 14'h0000, 1'b0);
    u_ctl.send(3'h2, 14'h0000, 1'b0);
    cmp(reg_three, 14'h0007);
    cmp(reg_two, 14'h0680);
    $display("test hold done");
  endtask
  // A reset in mid-run clears both registers, and a load works right after it.
  task automatic t_reset();
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    cmp(reg_two, 14'h0);
    cmp(reg_three, 14'h0);
    cmp(ctrl, 7'h0);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    u_ctl.send(3'h2, 14'h0080, 1'b1);
    cmp(reg_two, 14'h0080);
    cmp(ctrl.self_refresh_double, 1'b1);
    cmp(reg_three, 14'h0);
    $display("test reset done");
  endtask
  initial begin
    repeat (5) @(negedge clk_i);
    cmp(reg_two, 14'h0);
    cmp(reg_three, 14'h0);
    cmp(ctrl, 7'h0);
    cmp(rdat, 8'h00);
    reset_i = 1'b0;
    repeat (3) @(negedge clk_i);
    t_reg_two();
    t_reg_three();
    t_hold();
    t_reset();
    close_out();
  end
endmodule // tb_mrdec_top
`default_nettype wire
